// file: hdl/dtg_map.svh
// dtg_map.svh: register offsets, field positions and reset values for the debug/test mode guard
// assumes a 32-bit classic wishbone slave, byte addresses, one register per aligned word
//
// Functional notes
// - debug enable pin low holds the jtag tap controller in reset
// - debug enable pin high releases the tap controller for debug entry
// - debug mode active while debug enable pin low reports a fault
// - after erroneous debug activation, all later jtag input is rejected
// - watchdog freeze bit zero keeps watchdog counting in debug mode
// - system timer freeze bit zero keeps system timer running in debug
// - serial port freeze bit zero lets active spi transfers complete in debug
// - can freeze bit zero keeps can communicating in debug mode
// - periodic timer freeze bit zero keeps periodic timer running in debug
// - interrupt controller behaves identically in debug, no freeze control
// - dma debug halt bit zero keeps dma operating in debug mode
// - link freeze bit zero keeps inter-processor link transferring in debug
// - sent receiver freeze bit zero keeps sent receiver running in debug
// - factory test mode activation reports a fault
`ifndef DTG_MAP_SVH
`define DTG_MAP_SVH

// register byte offsets
`define DTG_OFS_FREEZE 4'h0
`define DTG_OFS_STATUS 4'h4
`define DTG_OFS_CLEAR 4'h8
`define DTG_OFS_IRQ_EN 4'hc

// freeze control field positions
`define DTG_FRZ_WDOG 0
`define DTG_FRZ_SYSTMR 1
`define DTG_FRZ_SPI 2
`define DTG_FRZ_CAN 3
`define DTG_FRZ_PERTMR 4
`define DTG_FRZ_DMA 5
`define DTG_FRZ_LINK 6
`define DTG_FRZ_SENT 7
`define DTG_FRZ_W 8

// status/event field positions
`define DTG_EV_DBG_FAULT 0
`define DTG_EV_TEST_FAULT 1
`define DTG_EV_DBG_ENTRY 2
`define DTG_EV_W 3

// reset values: nothing frozen, so safety modules keep running by default
`define DTG_FREEZE_RST 8'h00
`define DTG_IRQ_EN_RST 3'h0

`endif

// file: hdl/dtg_pkg.sv
// dtg_pkg.sv: types for the debug/test mode guard
// assumes dtg_map.svh is included alongside
package dtg_pkg;
  // debug guard state
  typedef enum logic [1:0] {
    DTG_NORMAL,
    DTG_DEBUG,
    DTG_LOCKED
  } dtg_state_e;
endpackage

// file: hdl/dtg_sync.sv
// dtg_sync.sv: two-flop synchroniser for one pin level
// assumes the pin is asynchronous to clk_i
`timescale 1ns/100ps
module dtg_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin and synchronised level
  input wire logic pin_i,
  output logic sync_o
);
  logic meta_r;

  // first stage is read only by the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_o <= meta_r;
    end
  end
endmodule

// file: hdl/dtg_guard.sv
// dtg_guard.sv: debug and factory test mode guard with wishbone registers
// assumes pins are asynchronous and pass dtg_sync; peripherals obey the run enables given here
`timescale 1ns/100ps
`include "dtg_map.svh"
module dtg_guard (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pins
  input wire logic debug_enable_pin_i,
  input wire logic factory_test_pin_i,
  // debug request from the jtag port controller and its command strobe
  input wire logic debug_req_i,
  input wire logic jtag_cmd_i,
  // jtag port controller control
  output logic tap_reset_o,
  output logic jtag_cmd_valid_o,
  output logic debug_mode_o,
  output dtg_pkg::dtg_state_e state_o,
  // fault collector reports, one-cycle pulses
  output logic fault_debug_o,
  output logic fault_test_o,
  // peripheral run enables, high means keep running
  output logic wdog_run_o,
  output logic systmr_run_o,
  output logic spi_run_o,
  output logic can_run_o,
  output logic pertmr_run_o,
  output logic irqctl_run_o,
  output logic dma_run_o,
  output logic link_run_o,
  output logic sent_run_o,
  // interrupt
  output logic irq_o
);
  import dtg_pkg::*;

  logic dbg_en_s;
  logic test_s;
  logic test_d_r;
  dtg_state_e state_r;
  dtg_state_e state_nxt;
  logic [`DTG_FRZ_W-1:0] freeze_r;
  logic [`DTG_EV_W-1:0] status_r;
  logic [`DTG_EV_W-1:0] irq_en_r;
  logic [`DTG_EV_W-1:0] ev;
  logic [`DTG_EV_W-1:0] clr;
  logic dbg_active;
  logic dbg_bad;
  logic dbg_enter;
  logic test_rise;

  // pins cross two flops before any logic looks at them
  dtg_sync u_sync_dbg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(debug_enable_pin_i),
    .sync_o(dbg_en_s)
  );
  dtg_sync u_sync_test (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(factory_test_pin_i),
    .sync_o(test_s)
  );

  // bus decode
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire wr_req = bus_req & we_i & sel_i[0];
  wire hit_freeze = (adr_i == `DTG_OFS_FREEZE);
  wire hit_status = (adr_i == `DTG_OFS_STATUS);
  wire hit_clear = (adr_i == `DTG_OFS_CLEAR);
  wire hit_irq_en = (adr_i == `DTG_OFS_IRQ_EN);
  wire wr_freeze = wr_req & hit_freeze;
  wire wr_clear = wr_req & hit_clear;
  wire wr_irq_en = wr_req & hit_irq_en;
  // enable as it stands after this edge, so irq follows an enable write without lag
  wire [`DTG_EV_W-1:0] irq_en_nxt = wr_irq_en ? dat_i[`DTG_EV_W-1:0] : irq_en_r;
  // clear register is write-only; unmapped reads give zero
  wire [31:0] rd_data = hit_freeze ? {24'h000000, freeze_r} :
                        hit_status ? {29'h0000000, status_r} :
                        hit_irq_en ? {29'h0000000, irq_en_r} : 32'h00000000;

  // debug mode detection
  assign dbg_active = (state_r == DTG_DEBUG);
  // a debug request with the pin low can only come from a fault, since the tap is held
  assign dbg_bad = debug_req_i & ~dbg_en_s;
  assign dbg_enter = debug_req_i & dbg_en_s & (state_r == DTG_NORMAL);
  assign test_rise = test_s & ~test_d_r;

  // state: locked is sticky until reset so the jtag stays deaf
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DTG_NORMAL: begin
        if (dbg_bad) begin
          state_nxt = DTG_LOCKED;
        end else if (dbg_enter) begin
          state_nxt = DTG_DEBUG;
        end
      end
      DTG_DEBUG: begin
        if (dbg_bad) begin
          state_nxt = DTG_LOCKED;
        end else if (!debug_req_i) begin
          state_nxt = DTG_NORMAL;
        end
      end
      DTG_LOCKED: begin
        state_nxt = DTG_LOCKED;
      end
      default: begin
        state_nxt = DTG_NORMAL;
      end
    endcase
  end

  // events feeding sticky status bits
  assign ev[`DTG_EV_DBG_FAULT] = dbg_bad & (state_r != DTG_LOCKED);
  assign ev[`DTG_EV_TEST_FAULT] = test_rise;
  assign ev[`DTG_EV_DBG_ENTRY] = dbg_enter;
  assign clr = wr_clear ? dat_i[`DTG_EV_W-1:0] : {`DTG_EV_W{1'b0}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= DTG_NORMAL;
      test_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      test_d_r <= test_s;
    end
  end

  // registers; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freeze_r <= `DTG_FREEZE_RST;
      irq_en_r <= `DTG_IRQ_EN_RST;
      status_r <= {`DTG_EV_W{1'b0}};
    end else begin
      if (wr_freeze) begin
        freeze_r <= dat_i[`DTG_FRZ_W-1:0];
      end
      if (wr_irq_en) begin
        irq_en_r <= dat_i[`DTG_EV_W-1:0];
      end
      status_r <= (status_r & ~clr) | ev;
    end
  end

  // bus answer: ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_req ? rd_data : 32'h00000000;
    end
  end

  // jtag and fault outputs, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tap_reset_o <= 1'b1;
      jtag_cmd_valid_o <= 1'b0;
      debug_mode_o <= 1'b0;
      state_o <= DTG_NORMAL;
      fault_debug_o <= 1'b0;
      fault_test_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      tap_reset_o <= ~dbg_en_s | (state_nxt == DTG_LOCKED);
      jtag_cmd_valid_o <= jtag_cmd_i & dbg_en_s & (state_nxt != DTG_LOCKED);
      debug_mode_o <= (state_nxt == DTG_DEBUG);
      state_o <= state_nxt;
      fault_debug_o <= ev[`DTG_EV_DBG_FAULT];
      fault_test_o <= test_rise;
      irq_o <= |(((status_r & ~clr) | ev) & irq_en_nxt);
    end
  end

  // run enables: a set freeze bit halts the module only while debug lasts
  // an erroneous debug activation also counts as debug, so freeze bits still matter
  wire dbg_next = (state_nxt != DTG_NORMAL);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdog_run_o <= 1'b1;
      systmr_run_o <= 1'b1;
      spi_run_o <= 1'b1;
      can_run_o <= 1'b1;
      pertmr_run_o <= 1'b1;
      irqctl_run_o <= 1'b1;
      dma_run_o <= 1'b1;
      link_run_o <= 1'b1;
      sent_run_o <= 1'b1;
    end else begin
      wdog_run_o <= ~(dbg_next & freeze_r[`DTG_FRZ_WDOG]);
      systmr_run_o <= ~(dbg_next & freeze_r[`DTG_FRZ_SYSTMR]);
      spi_run_o <= ~(dbg_next & freeze_r[`DTG_FRZ_SPI]);
      can_run_o <= ~(dbg_next & freeze_r[`DTG_FRZ_CAN]);
      pertmr_run_o <= ~(dbg_next & freeze_r[`DTG_FRZ_PERTMR]);
      irqctl_run_o <= 1'b1;
      dma_run_o <= ~(dbg_next & freeze_r[`DTG_FRZ_DMA]);
      link_run_o <= ~(dbg_next & freeze_r[`DTG_FRZ_LINK]);
      sent_run_o <= ~(dbg_next & freeze_r[`DTG_FRZ_SENT]);
    end
  end
endmodule

// file: verification/dtg_guard_monitor.sv
// dtg_guard_monitor.sv: bus and guard checks on the dtg_guard ports
// assumes one clock domain and the sync reset of dtg_guard
`timescale 1ns/100ps
module dtg_guard_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  // guard
  input wire logic jtag_cmd_i,
  input wire logic tap_reset_o,
  input wire logic jtag_cmd_valid_o,
  input wire dtg_pkg::dtg_state_e state_o,
  input wire logic fault_debug_o,
  input wire logic wdog_run_o,
  input wire logic irqctl_run_o
);
  import dtg_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // single cycle answer, never stretched
  chk_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack stretched");
  chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("data without ack");
  // lock is sticky and keeps the port shut
  chk_lock_tap: assert property (state_o == DTG_LOCKED |-> tap_reset_o && !jtag_cmd_valid_o)
    else $error("locked port open");
  chk_lock_hold: assert property (state_o == DTG_LOCKED |=> state_o == DTG_LOCKED)
    else $error("lock left");
  chk_fault_once: assert property (fault_debug_o |-> state_o == DTG_LOCKED && $past(state_o) != DTG_LOCKED)
    else $error("fault pulse misplaced");
  chk_irqctl_run: assert property (irqctl_run_o) else $error("interrupt unit stopped");
  chk_cmd_cause: assert property (jtag_cmd_valid_o |-> $past(jtag_cmd_i)) else $error("cmd from nowhere");
  chk_run_normal: assert property (state_o == DTG_NORMAL |-> wdog_run_o) else $error("wdog frozen");
endmodule
bind dtg_guard dtg_guard_monitor i_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .dat_o, .jtag_cmd_i,
  .tap_reset_o, .jtag_cmd_valid_o, .state_o, .fault_debug_o, .wdog_run_o, .irqctl_run_o);

// file: verification/dtg_debugger_model.sv
// dtg_debugger_model.sv: external debugger, owns the debug enable pin
// assumes the bench steers it with en_i and go_i at clock edges
`timescale 1ns/100ps
module dtg_debugger_model (
  // control from bench
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic go_i,
  // debug side
  output logic pin_o,
  output logic req_o,
  output logic cmd_o
);
  // pin starts low so boot never sees debug enabled
  initial {pin_o, req_o, cmd_o} = 3'h0;
  // commands every other cycle, a slow debugger
  always @(posedge clk_i) begin
    pin_o <= en_i;
    req_o <= go_i;
    cmd_o <= go_i & ~cmd_o;
  end
endmodule

// file: verification/tb_dtg_guard.sv
// tb_dtg_guard.sv: directed register and guard sequences for dtg_guard
// assumes the debugger model and the bound monitor
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb_dtg_guard;
  import dtg_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, tp = 1'b0, en = 1'b0, go = 1'b0, pin, req, cmd, tap_reset_o, jval, dbg, fd, ft, irq_o;
  logic wd, systmr, spi, can, pertmr, irqctl, dma, lnk, snt;
  dtg_state_e st;
  int errors = 0, checked = 0, nfd = 0, ntf = 0, nval = 0, v;
  wire [7:0] runs = {snt, lnk, dma, pertmr, can, spi, systmr, wd};
  always #20 clk_i = ~clk_i;
  // pulse tallies, fed from design outputs
  always @(posedge clk_i) begin
    nfd <= nfd + fd;
    ntf <= ntf + ft;
    nval <= nval + jval;
  end
  dtg_debugger_model i_dbg (.clk_i(clk_i), .en_i(en), .go_i(go), .pin_o(pin), .req_o(req), .cmd_o(cmd));
  dtg_guard i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .debug_enable_pin_i(pin),
    .factory_test_pin_i(tp), .debug_req_i(req), .jtag_cmd_i(cmd), .tap_reset_o(tap_reset_o),
    .jtag_cmd_valid_o(jval), .debug_mode_o(dbg), .state_o(st), .fault_debug_o(fd), .fault_test_o(ft),
    .wdog_run_o(wd), .systmr_run_o(systmr), .spi_run_o(spi), .can_run_o(can), .pertmr_run_o(pertmr),
    .irqctl_run_o(irqctl), .dma_run_o(dma), .link_run_o(lnk), .sent_run_o(snt), .irq_o(irq_o));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one classic cycle, entered at an edge; read data checked against e
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
    int k;
    k = 0;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
    do begin @(posedge clk_i); k++; end while (!ack_o && k < 20);
    if (!ack_o) errors++;
    if (!w) `CHK(dat_o, e)
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic print_verdict;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    print_verdict;
  end
  initial begin
    tick(8);
    rst_i <= 1'b0;
    tick(1);
    `CHK(tap_reset_o, 1'b1)
    `CHK({irqctl, runs}, 9'h1ff)
    wb(0, 4'h0, 0, 0);
    wb(0, 4'h4, 0, 0);
    wb(0, 4'h2, 0, 0);
    wb(1, 4'hc, 7, 0);
    wb(0, 4'hc, 0, 7);
    // legal session, nothing frozen
    en <= 1'b1;
    tick(5);
    `CHK(tap_reset_o, 1'b0)
    go <= 1'b1;
    tick(6);
    `CHK({dbg, st}, {1'b1, DTG_DEBUG})
    `CHK(nval != 0, 1'b1)
    `CHK(runs, 8'hff)
    wb(0, 4'h4, 0, 4);
    `CHK(irq_o, 1'b1)
    go <= 1'b0;
    tick(4);
    `CHK(st, DTG_NORMAL)
    // walk one freeze bit at a time
    for (int i = 0; i < 8; i++) begin
      wb(1, 4'h0, 32'h1 << i, 0);
      go <= 1'b1;
      tick(4);
      `CHK(runs, ~(8'h1 << i))
      go <= 1'b0;
      tick(4);
      `CHK(runs, 8'hff)
    end
    wb(1, 4'h0, 0, 0);
    wb(1, 4'h8, 7, 0);
    wb(0, 4'h4, 0, 0);
    `CHK(irq_o, 1'b0)
    tp <= 1'b1;
    tick(6);
    `CHK(ntf, 1)
    tp <= 1'b0;
    wb(0, 4'h4, 0, 2);
    // debug request with the pin low
    en <= 1'b0;
    tick(5);
    `CHK(tap_reset_o, 1'b1)
    v = nval;
    go <= 1'b1;
    tick(8);
    `CHK(nfd, 1)
    `CHK({st, runs}, {DTG_LOCKED, 8'hff})
    en <= 1'b1;
    tick(8);
    `CHK({tap_reset_o, nval}, {1'b1, v})
    wb(0, 4'h8, 0, 0);
    wb(0, 4'h4, 0, 3);
    go <= 1'b0;
    rst_i <= 1'b1;
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    `CHK(st, DTG_NORMAL)
    wb(0, 4'h4, 0, 0);
    // pin drops in the middle of a legal session, watchdog frozen
    wb(1, 4'h0, 32'h1, 0);
    go <= 1'b1;
    tick(4);
    `CHK(st, DTG_DEBUG)
    en <= 1'b0;
    tick(6);
    `CHK({st, nfd, wd}, {DTG_LOCKED, 32'd2, 1'b0})
    wb(0, 4'h4, 0, 5);
    print_verdict;
  end
endmodule
